// ==== assess_pkg.sv ====
// Constants and types shared by the channel assessment and link quality block
package assess_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] CFG_ADDR    = 8'h00; // Channel and assess config
    localparam logic [7:0] THRES_ADDR  = 8'h04; // Threshold config
    localparam logic [7:0] STATUS_ADDR = 8'h08; // Transceiver status
    localparam logic [7:0] SYNC_ADDR   = 8'h0c; // Rx sync config
    localparam logic [7:0] IRQ_ADDR    = 8'h10; // Interrupt status, write one to clear
    localparam logic [7:0] MASK_ADDR   = 8'h14; // Interrupt mask
    localparam logic [7:0] LQI_ADDR    = 8'h18; // Last link quality value

    // ==========================================================
    // Field positions
    localparam int MODE_LSB    = 5;  // Mode field bits 6:5
    localparam int REQ_BIT     = 7;  // Assess request bit
    localparam int DONE_BIT    = 7;  // Completion flag in status
    localparam int IDLE_BIT    = 6;  // Channel-idle flag in status
    localparam int PDT_DIS_BIT = 7;  // Preamble detect disable
    localparam int IRQ_DONE    = 0;  // Measurement done interrupt
    localparam int IRQ_RXEND   = 1;  // Frame received interrupt

    // ==========================================================
    // Reset values
    localparam logic [1:0] MODE_RST  = 2'h1;
    localparam logic [3:0] THRES_RST = 4'h7;
    localparam logic [7:0] LQI_RST   = 8'h00;

    // ==========================================================
    // Timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int RESULT_US     = 140;  // Request to readable result
    localparam int RESULT_CYC    = (RESULT_US * (CLK_HZ / 1_000_000));
    localparam int AUTO_ED_US    = 128;  // Eight symbols of 16 us
    localparam int AUTO_ED_CYC   = (AUTO_ED_US * (CLK_HZ / 1_000_000));
    localparam int MIN_LQI_OCT   = 2;    // Shortest PSDU with a valid quality value

    // Receiver states as seen by this block
    typedef enum logic [1:0] {RX_OFF_S, RX_LISTEN_S, RX_BUSY_S} rx_state_type;
    typedef enum logic [1:0] {IDLE_ST, MEASURE_ST, WAIT_ED_ST} meas_state_type;

endpackage

// ==== channel_assessment_lqi.sv ====
// Channel assessment and link quality logic with register port
// Operation
// - Software picks one of four assessment modes
// - Request bit starts assessment in receive states
// - Listening assessment result readable after 140 us
// - Done interrupt at end of manual assessment
// - Energy busy above base plus twice threshold
// - Request clears completion and idle flags
// - Completion set at end; idle if quiet
// - Carrier sense detection marks channel busy
// - Request outside receive still completes and interrupts
// - Busy-receive energy modes wait for auto measurement
// - Carrier mode or post-measurement requests answer immediately
// - One automatic energy measurement per frame
// - Preamble disable keeps receiver listening
// - Quality from symbol correlations, two-octet minimum
// - Quality byte appended to each received frame
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
module channel_assessment_lqi #(
    parameter int RESULT_CYCLES = assess_pkg::RESULT_CYC,
    parameter int AUTO_ED_CYCLES = assess_pkg::AUTO_ED_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            irq,
    input  wire logic       rx_enabled,
    input  wire logic       ext_mode,
    input  wire logic       shr_detected,
    input  wire logic       frame_end,
    input  wire logic [7:0] psdu_len,
    input  wire logic       corr_valid,
    input  wire logic [7:0] corr_value,
    input  wire logic       carrier_det,
    input  wire logic [6:0] rx_power,
    input  wire logic [6:0] base_level,
    output logic            rx_busy,
    output logic            fb_wr,
    output logic      [7:0] fb_wdata,
    output logic            measure_done_irq,
    output logic            frame_received_irq
);

    // ==========================================================
    // Registers
    logic [1:0]                  mode_r;
    logic [3:0]                  thres_r;
    logic                        pdt_dis_r;
    logic                        done_r;
    logic                        idle_r;
    logic [1:0]                  irq_stat_r;
    logic [1:0]                  irq_mask_r;
    logic [7:0]                  lqi_r;
    logic [15:0]                 cnt_r;
    logic [15:0]                 ed_cnt_r;
    logic                        ed_run_r;
    logic                        ed_done_r;
    logic                        energy_busy_r;
    logic                        carrier_seen_r;
    logic                        ed_busy_r;
    logic [15:0]                 lqi_sum_r;
    logic [7:0]                  lqi_n_r;
    assess_pkg::meas_state_type  meas_r;

    logic       req;
    logic       finish;
    logic       energy_now;
    logic [7:0] thres_lvl;
    logic       quiet;
    logic [1:0] mode_eff;

    // Energy compare against base level plus 2 dB per threshold step
    assign thres_lvl  = {1'b0, base_level} + {3'h0, thres_r, 1'b0};
    assign energy_now = ({1'b0, rx_power} > thres_lvl);
    assign req = reg_wr && (reg_addr == assess_pkg::CFG_ADDR)
                 && reg_wdata[assess_pkg::REQ_BIT];
    // Mode that applies to a request: the same write may change it
    assign mode_eff = req ? reg_wdata[assess_pkg::MODE_LSB +: 2] : mode_r;

    // Mode decode used for final verdict and busy-receive wait
    function automatic logic needs_energy(input logic [1:0] m);
        needs_energy = (m != 2'h2);
    endfunction

    function automatic logic verdict_idle(input logic [1:0] m, input logic e, input logic c);
        case (m)
            2'h1:    verdict_idle = !e;
            2'h2:    verdict_idle = !c;
            2'h3:    verdict_idle = !(e && c);
            default: verdict_idle = !(e || c);
        endcase
    endfunction

    // ==========================================================
    // Configuration registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r     <= assess_pkg::MODE_RST;
            thres_r    <= assess_pkg::THRES_RST;
            pdt_dis_r  <= 1'b0;
            irq_mask_r <= 2'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                assess_pkg::CFG_ADDR:   mode_r <= reg_wdata[assess_pkg::MODE_LSB +: 2];
                assess_pkg::THRES_ADDR: thres_r <= reg_wdata[3:0];
                assess_pkg::SYNC_ADDR:  pdt_dis_r <= reg_wdata[assess_pkg::PDT_DIS_BIT];
                assess_pkg::MASK_ADDR:  irq_mask_r <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Receiver state: listening unless a header arrives, busy until frame end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_busy <= 1'b0;
        end else if (!rx_enabled || frame_end) begin
            rx_busy <= 1'b0;
        end else if (shr_detected && !pdt_dis_r) begin
            rx_busy <= 1'b1;
        end
    end

    // Automatic energy measurement, started once per frame on header
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ed_run_r  <= 1'b0;
            ed_done_r <= 1'b0;
            ed_cnt_r  <= 16'h0000;
            ed_busy_r <= 1'b0;
        end else if (!rx_busy && shr_detected && !pdt_dis_r && rx_enabled) begin
            ed_run_r  <= 1'b1;
            ed_done_r <= 1'b0;
            ed_cnt_r  <= 16'h0000;
            ed_busy_r <= 1'b0;
        end else if (ed_run_r) begin
            ed_busy_r <= ed_busy_r | energy_now;
            if (ed_cnt_r == 16'(AUTO_ED_CYCLES - 1)) begin
                ed_run_r  <= 1'b0;
                ed_done_r <= 1'b1;
            end else begin
                ed_cnt_r <= ed_cnt_r + 16'h0001;
            end
        end else if (!rx_busy) begin
            ed_done_r <= 1'b0;
        end
    end

    // ==========================================================
    // Manual assessment sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meas_r         <= assess_pkg::IDLE_ST;
            cnt_r          <= 16'h0000;
            energy_busy_r  <= 1'b0;
            carrier_seen_r <= 1'b0;
        end else if (req) begin
            cnt_r          <= 16'h0000;
            energy_busy_r  <= 1'b0;
            carrier_seen_r <= 1'b0;
            if (!rx_enabled || ext_mode)
                meas_r <= assess_pkg::IDLE_ST;
            else if (!rx_busy)
                meas_r <= assess_pkg::MEASURE_ST;
            else if (needs_energy(mode_eff) && !ed_done_r)
                meas_r <= assess_pkg::WAIT_ED_ST;
            else
                meas_r <= assess_pkg::IDLE_ST;
        end else begin
            case (meas_r)
                assess_pkg::MEASURE_ST: begin
                    energy_busy_r  <= energy_busy_r | energy_now;
                    carrier_seen_r <= carrier_seen_r | carrier_det;
                    if (cnt_r == 16'(RESULT_CYCLES - 1))
                        meas_r <= assess_pkg::IDLE_ST;
                    else
                        cnt_r <= cnt_r + 16'h0001;
                end
                assess_pkg::WAIT_ED_ST: begin
                    carrier_seen_r <= carrier_seen_r | carrier_det;
                    if (ed_done_r || !rx_busy)
                        meas_r <= assess_pkg::IDLE_ST;
                end
                default: meas_r <= assess_pkg::IDLE_ST;
            endcase
        end
    end

    // Completion strobe: timer end, energy wait end, or immediate answer
    always_comb begin
        finish = 1'b0;
        quiet  = 1'b0;
        if (req && (!rx_enabled || ext_mode)) begin
            finish = 1'b1;
            quiet  = 1'b0;
        end else if (req && rx_busy && !(needs_energy(mode_eff) && !ed_done_r)) begin
            finish = 1'b1;
            quiet  = verdict_idle(mode_eff, ed_busy_r, carrier_det);
        end else if (!req && meas_r == assess_pkg::MEASURE_ST
                     && cnt_r == 16'(RESULT_CYCLES - 1)) begin
            finish = 1'b1;
            quiet  = verdict_idle(mode_r, energy_busy_r | energy_now,
                                  carrier_seen_r | carrier_det);
        end else if (!req && meas_r == assess_pkg::WAIT_ED_ST && (ed_done_r || !rx_busy)) begin
            finish = 1'b1;
            quiet  = verdict_idle(mode_r, ed_busy_r, carrier_seen_r | carrier_det);
        end
    end

    // Status flags: request clears, end of cycle sets; set wins
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
            idle_r <= 1'b0;
        end else if (finish) begin
            done_r <= 1'b1;
            idle_r <= quiet;
        end else if (req) begin
            done_r <= 1'b0;
            idle_r <= 1'b0;
        end
    end

    // Done pulse, one clock per finished assessment
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            measure_done_irq <= 1'b0;
        end else begin
            measure_done_irq <= finish;
        end
    end

    // ==========================================================
    // Link quality: mean of correlation results, appended at frame end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lqi_sum_r <= 16'h0000;
            lqi_n_r   <= 8'h00;
            lqi_r     <= assess_pkg::LQI_RST;
            fb_wr     <= 1'b0;
            fb_wdata  <= 8'h00;
            frame_received_irq <= 1'b0;
        end else begin
            fb_wr <= 1'b0;
            frame_received_irq <= 1'b0;
            if (shr_detected && !rx_busy) begin
                lqi_sum_r <= 16'h0000;
                lqi_n_r   <= 8'h00;
            end else if (rx_busy && corr_valid && lqi_n_r != 8'hff) begin
                lqi_sum_r <= lqi_sum_r + {8'h00, corr_value};
                lqi_n_r   <= lqi_n_r + 8'h01;
            end
            if (rx_busy && frame_end) begin
                // Short frames report zero, the value is not meaningful
                if (psdu_len >= 8'(assess_pkg::MIN_LQI_OCT) && lqi_n_r != 8'h00) begin
                    lqi_r    <= 8'(lqi_sum_r / {8'h00, lqi_n_r});
                    fb_wdata <= 8'(lqi_sum_r / {8'h00, lqi_n_r});
                end else begin
                    lqi_r    <= 8'h00;
                    fb_wdata <= 8'h00;
                end
                fb_wr <= 1'b1;
                frame_received_irq <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Interrupt status and output; set wins over clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == assess_pkg::IRQ_DONE && measure_done_irq)
                    || (i == assess_pkg::IRQ_RXEND && frame_received_irq))
                    irq_stat_r[i] <= 1'b1;
                else if (reg_wr && reg_addr == assess_pkg::IRQ_ADDR && reg_wdata[i])
                    irq_stat_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_r & irq_mask_r);
    end

    // Read data, valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                assess_pkg::CFG_ADDR:    reg_rdata <= {1'b0, mode_r, 5'h00};
                assess_pkg::THRES_ADDR:  reg_rdata <= {4'h0, thres_r};
                assess_pkg::STATUS_ADDR: reg_rdata <= {done_r, idle_r, 5'h00, rx_busy};
                assess_pkg::SYNC_ADDR:   reg_rdata <= {pdt_dis_r, 7'h00};
                assess_pkg::IRQ_ADDR:    reg_rdata <= {6'h00, irq_stat_r};
                assess_pkg::MASK_ADDR:   reg_rdata <= {6'h00, irq_mask_r};
                assess_pkg::LQI_ADDR:    reg_rdata <= lqi_r;
                default:                 reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Checks
    sequence req_listen_s;
        req && rx_enabled && !ext_mode && !rx_busy;
    endsequence

    listen_done_time_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        req_listen_s ##1 (!req && !rx_busy) [*8] |-> !finish)
        else $error("listening assessment finished too early");

    clear_on_req_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        req && !finish |=> !done_r && !idle_r)
        else $error("request did not clear flags");

    done_sets_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        finish |=> done_r && measure_done_irq)
        else $error("completion not flagged");

    done_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        measure_done_irq && !finish |=> !measure_done_irq)
        else $error("done pulse longer than one cycle");

    outside_rx_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        req && (!rx_enabled || ext_mode) |=> done_r && !idle_r && measure_done_irq)
        else $error("request outside receive not completed");

    wait_ed_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        meas_r == assess_pkg::WAIT_ED_ST && !ed_done_r && rx_busy && !req |-> !finish)
        else $error("busy-receive result before energy measurement");

    carrier_now_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        req && rx_enabled && !ext_mode && rx_busy && mode_eff == 2'h2 |-> finish)
        else $error("carrier mode not immediate");

    lqi_append_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rx_busy && frame_end |=> fb_wr && frame_received_irq && fb_wdata == lqi_r)
        else $error("quality byte not appended");

    pdt_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        pdt_dis_r && !rx_busy |=> !rx_busy)
        else $error("header accepted while detection disabled");

    // Completion stays set until a new request clears it
    done_sticky_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        done_r && !req |=> done_r)
        else $error("completion flag lost without request");

    // A header inside a frame must not start a second energy measurement
    auto_ed_once_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rx_busy && shr_detected |=> !$rose(ed_run_r))
        else $error("second automatic energy measurement in one frame");

    // Frames too short for a valid quality value report zero
    short_frame_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rx_busy && frame_end && psdu_len < 8'(assess_pkg::MIN_LQI_OCT)
        |=> fb_wdata == 8'h00)
        else $error("short frame quality byte not zero");

    // Interrupt line follows the unmasked status one cycle later
    irq_level_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (|(irq_stat_r & irq_mask_r)) |=> irq)
        else $error("interrupt line not raised");

endmodule // channel_assessment_lqi

// ==== tb_top.sv ====
// Self-checking bench for the channel assessment and link quality block
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // Signals and bench state
    localparam int RC = 20; // Short listen measurement keeps the run brief
    localparam int AC = 10; // Short automatic energy measurement
    logic       ref_clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       irq;
    logic       rx_enabled = 1'b0;
    logic       ext_mode = 1'b0;
    logic       shr_detected = 1'b0;
    logic       frame_end = 1'b0;
    logic [7:0] psdu_len = 8'h00;
    logic       corr_valid = 1'b0;
    logic [7:0] corr_value = 8'h00;
    logic       carrier_det = 1'b0;
    logic [6:0] rx_power = 7'h00;
    logic [6:0] base_level = 7'h14;
    logic       rx_busy;
    logic       fb_wr;
    logic [7:0] fb_wdata;
    logic       measure_done_irq;
    logic       frame_received_irq;
    int         n_errors = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    int         n;
    logic [7:0] d;
    // Listen cases: mode, carrier, power, threshold, expected idle flag
    logic [1:0] t_mode [0:8] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h0};
    logic       t_car  [0:8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [6:0] t_pwr  [0:8] = '{7'h22, 7'h23, 7'h1b, 7'h00, 7'h5a, 7'h23, 7'h22, 7'h23, 7'h22};
    logic [7:0] t_thr  [0:8] = '{8'h07, 8'h07, 8'h03, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07};
    logic       t_idle [0:8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    channel_assessment_lqi #(.RESULT_CYCLES(RC), .AUTO_ED_CYCLES(AC)) channel_assessment_lqi_inst (
        .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .rx_enabled(rx_enabled), .ext_mode(ext_mode), .shr_detected(shr_detected),
        .frame_end(frame_end), .psdu_len(psdu_len), .corr_valid(corr_valid),
        .corr_value(corr_value), .carrier_det(carrier_det), .rx_power(rx_power),
        .base_level(base_level), .rx_busy(rx_busy), .fb_wr(fb_wr), .fb_wdata(fb_wdata),
        .measure_done_irq(measure_done_irq), .frame_received_irq(frame_received_irq));

    // ==========================================================
    // Clock and hang guard
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    // ==========================================================
    // Bus, pulse and compare helpers
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Counts edges until the one-cycle done pulse shows, bounded
    task automatic wait_done(output int c);
        c = 0;
        #1;
        while (measure_done_irq !== 1'b1 && c < 200) begin
            @(posedge ref_clk);
            #1 c++;
        end
        chk("done_pulse", measure_done_irq, 1'b1);
        @(posedge ref_clk);
        #1 chk("done_one_cycle", measure_done_irq, 1'b0);
    endtask
    task automatic pulse_shr();
        @(posedge ref_clk);
        shr_detected <= 1'b1;
        @(posedge ref_clk);
        shr_detected <= 1'b0;
    endtask
    task automatic req(input logic [1:0] m);
        wr(assess_pkg::CFG_ADDR, {1'b1, m, 5'h00});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd(assess_pkg::CFG_ADDR, d);   chk("cfg_rst", d & 8'he0, 8'h20);
        rd(assess_pkg::THRES_ADDR, d); chk("thr_rst", d & 8'h0f, 8'h07);
        rd(assess_pkg::STATUS_ADDR, d); chk("status_rst", d, 8'h00);
        rd(assess_pkg::LQI_ADDR, d);   chk("lqi_rst", d, 8'h00);
        rd(8'h1c, d);                  chk("unmapped", d, 8'h00);
    endtask
    // Every mode and threshold boundary while listening, irq raised then cleared
    task automatic t_listen();
        rx_enabled <= 1'b1;
        wr(assess_pkg::MASK_ADDR, 8'h01);
        for (int i = 0; i < 9; i++) begin
            carrier_det <= t_car[i]; rx_power <= t_pwr[i];
            wr(assess_pkg::THRES_ADDR, t_thr[i]);
            req(t_mode[i]);
            rd(assess_pkg::STATUS_ADDR, d); chk("flags_cleared", d & 8'hc0, 8'h00);
            wait_done(n);
            chk("listen_time", 8'(n >= RC - 2 && n <= RC + 2), 8'h01);
            rd(assess_pkg::STATUS_ADDR, d);
            chk("listen_result", d & 8'hc1, {1'b1, t_idle[i], 6'h00});
            chk("irq_raised", irq, 1'b1);
            wr(assess_pkg::IRQ_ADDR, 8'h01);
            rd(assess_pkg::IRQ_ADDR, d); chk("irq_cleared", d & 8'h01, 8'h00);
            chk("irq_low", irq, 1'b0);
        end
        wr(assess_pkg::THRES_ADDR, 8'h07);
    endtask
    // Requests outside basic receive states complete at once, busy reported
    task automatic t_outside();
        wr(assess_pkg::MASK_ADDR, 8'h00);
        rx_enabled <= 1'b0;
        req(2'h2); wait_done(n);
        chk("off_time", 8'(n <= 2), 8'h01);
        rd(assess_pkg::STATUS_ADDR, d); chk("off_flags", d & 8'hc0, 8'h80);
        chk("irq_masked", irq, 1'b0);
        rd(assess_pkg::IRQ_ADDR, d); chk("irq_sticky", d & 8'h01, 8'h01);
        rx_enabled <= 1'b1; ext_mode <= 1'b1;
        req(2'h1); wait_done(n);
        chk("ext_time", 8'(n <= 2), 8'h01);
        ext_mode <= 1'b0;
        wr(assess_pkg::IRQ_ADDR, 8'h03);
    endtask
    // Preamble disable holds the listening state and the long measurement
    task automatic t_pdt();
        wr(assess_pkg::SYNC_ADDR, 8'h80);
        pulse_shr();
        #1 chk("pdt_no_busy", rx_busy, 1'b0);
        req(2'h1); wait_done(n);
        chk("pdt_time", 8'(n >= RC - 2), 8'h01);
        wr(assess_pkg::SYNC_ADDR, 8'h00);
    endtask
    // Busy receive: carrier mode at once, energy modes wait for the auto measurement
    task automatic t_busy();
        carrier_det <= 1'b0; rx_power <= 7'h00;
        pulse_shr();
        rd(assess_pkg::STATUS_ADDR, d); chk("busy_state", d & 8'h01, 8'h01);
        req(2'h2); wait_done(n); chk("busy_m2", 8'(n <= 2), 8'h01);
        req(2'h1); wait_done(n); chk("busy_m1_wait", 8'(n >= 2 && n <= AC + 2), 8'h01);
        rd(assess_pkg::STATUS_ADDR, d); chk("busy_m1_res", d & 8'hc0, 8'hc0);
        req(2'h3); wait_done(n); chk("busy_m3_after", 8'(n <= 2), 8'h01);
        pulse_shr();
        req(2'h0); wait_done(n); chk("one_auto_ed", 8'(n <= 2), 8'h01);
    endtask
    // Quality byte appended at frame end, zero for short frames
    task automatic frame(input logic [7:0] len, input logic [7:0] exp);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            corr_valid <= 1'b1; corr_value <= 8'h40 + 8'(32 * i);
        end
        @(posedge ref_clk);
        corr_valid <= 1'b0; frame_end <= 1'b1; psdu_len <= len;
        @(posedge ref_clk);
        frame_end <= 1'b0;
        #1 chk("fb_wr", fb_wr, 1'b1);
        chk("fb_wdata", fb_wdata, exp);
        chk("rx_end_irq", frame_received_irq, 1'b1);
        rd(assess_pkg::LQI_ADDR, d); chk("lqi_reg", d, exp);
        rd(assess_pkg::IRQ_ADDR, d); chk("rx_end_status", d & 8'h02, 8'h02);
        wr(assess_pkg::IRQ_ADDR, 8'h02);
    endtask
    task automatic t_lqi();
        frame(8'h14, 8'h70);
        pulse_shr();
        frame(8'h01, 8'h00);
    endtask

    // ==========================================================
    // Verdict and main sequence
    task automatic summarize();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_listen();
        t_outside();
        t_pdt();
        t_busy();
        t_lqi();
        summarize();
    end
endmodule // tb_top
